// ### common/sps_pkg.sv
// Constants and types shared by the two-wire slave port, its checker and its bench.
// Assumes nothing.
package sps_pkg;

   localparam int unsigned BYTE_W   = 8;
   localparam int unsigned RX_DEPTH = 32;

   // Mode field encodings
   localparam logic [3:0] MODE_SLV7      = 4'h6;
   localparam logic [3:0] MODE_SLV10     = 4'h7;
   localparam logic [3:0] MODE_FW_IDLE   = 4'hB;
   localparam logic [3:0] MODE_SLV7_SP   = 4'hE;
   localparam logic [3:0] MODE_SLV10_SP  = 4'hF;

   // 10-bit address first byte prefix
   localparam logic [4:0] TEN_PREFIX     = 5'h1E;
   localparam logic [3:0] LAST_BIT       = 4'h7;
   localparam logic [3:0] BYTE_BITS      = 4'h8;

   // 10-bit address progress
   localparam logic [1:0] TEN_NONE       = 2'h0;
   localparam logic [1:0] TEN_HIGH_OK    = 2'h1;
   localparam logic [1:0] TEN_FULL_OK    = 2'h2;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ADDR = 6'h02,
      ST_ACK  = 6'h04,
      ST_RX   = 6'h08,
      ST_TX   = 6'h10,
      ST_MACK = 6'h20
   } sps_state_t;

endpackage

// ### common/sps_stream_if.sv
// Valid/ready byte stream between the slave port and its receive buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface sps_stream_if #(parameter int unsigned WIDTH = 8);
   logic [WIDTH-1:0] data;
   logic             valid;
   logic             ready;

   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// ### design/sps_rx_fifo.sv
// Receive buffer: memory plus a registered output stage.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps
module sps_rx_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 32
) (
   input  wire logic clk,     // System clock
   input  wire logic rst_b,   // Asynchronous reset, active low
   sps_stream_if.snk in_s,    // Filling side
   sps_stream_if.src out_s    // Draining side
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr,   next_wr_ptr;
   logic [AW-1:0]    rd_ptr,   next_rd_ptr;
   logic [AW:0]      count,    next_count;
   logic [WIDTH-1:0] out_data, next_out_data;
   logic             out_vld,  next_out_vld;
   logic             in_rdy,   next_in_rdy;
   logic             wr_en;
   logic             rd_en;

   assign in_s.ready  = in_rdy;
   assign out_s.data  = out_data;
   assign out_s.valid = out_vld;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      wr_en         = in_s.valid && in_rdy;
      rd_en         = (count != '0) && (!out_vld || out_s.ready);
      next_wr_ptr   = wr_en ? AW'(wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr   = rd_en ? AW'(rd_ptr + 1'b1) : rd_ptr;
      next_count    = (AW+1)'(count + {{AW{1'b0}}, wr_en}
                                    - {{AW{1'b0}}, rd_en});
      next_out_data = rd_en ? mem[rd_ptr] : out_data;
      next_out_vld  = rd_en ? 1'b1 : (out_vld && !out_s.ready);
      // Output stage adds one slot
      next_in_rdy   = (next_count != (AW+1)'(DEPTH));
   end

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_ptr] <= in_s.data;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr   <= '0;
         rd_ptr   <= '0;
         count    <= '0;
         out_data <= '0;
         out_vld  <= 1'b0;
         in_rdy   <= 1'b1;
      end else begin
         wr_ptr   <= next_wr_ptr;
         rd_ptr   <= next_rd_ptr;
         count    <= next_count;
         out_data <= next_out_data;
         out_vld  <= next_out_vld;
         in_rdy   <= next_in_rdy;
      end
   end
endmodule // sps_rx_fifo

// ### design/sps_i2c_slave.sv
// Two-wire serial port slave with start/stop events for firmware master.
// Assumes bus pins come from outside the clock domain; software signals
// are on clk. Pin enables are active low: low means the pin is pulled low.
//
// Notes on behaviour
// RULE1 - Full slave for 7-bit and 10-bit addresses; no general call.
// RULE2 - Start and stop conditions raise the interrupt flag for firmware in event slave modes and idle mode.
// RULE3 - Slave address and address mask held as separate registers.
// RULE4 - Enabled port makes clock and data pins open drain.
// RULE5 - Port overrides pins for acknowledge and transmit data.
// RULE6 - Sample on clock rise, change data on clock fall.
// RULE7 - Slew control bit drives pad slew limiters while enabled.
// RULE8 - Hidden shift register; bytes pass via buffer.
// RULE9 - Clock held low after a 10-bit address byte until address write.
// RULE10 - Clock held low while clock_release is clear.
// RULE11 - Software rewrites address after both 10-bit address bytes.
// RULE12 - Address update need sets its status bit and interrupt flag.
// RULE13 - Start and stop bits clear on reset and on port disable.
// RULE14 - Start and stop bits follow the most recent bus condition.
// RULE15 - Firmware master claims bus only after stop or when idle.
// RULE16 - Firmware master output is low; direction bit chooses level.
// RULE17 - Flag sets on each byte sent or received, and on start and stop in event slave modes and idle mode.
// RULE18 - Firmware master in idle mode or event slave modes.
// RULE19 - Interrupt enabled on busy bus fires at the next stop.
// RULE20 - Firmware watches data line and yields on arbitration loss.
// RULE21 - Slave keeps receiving after arbitration loss and acknowledges.
// RULE22 - Master waits until every device releases the clock line.
// RULE23 - Address match ignores bit positions cleared in the mask.
`timescale 1ns/10ps
module sps_i2c_slave
   import sps_pkg::*;
(
   input  wire logic              clk,                    // System clock
   input  wire logic              rst_b,                  // Async reset
   input  wire logic              scl_in,                 // Clock pin level
   input  wire logic              sda_in,                 // Data pin level
   output logic                   scl_out,                // Clock pin data
   output logic                   scl_oe_b,               // Clock drive en
   output logic                   sda_out,                // Data pin data
   output logic                   sda_oe_b,               // Data drive en
   output logic                   slew_limit,             // Pad slew ctl
   input  wire logic              port_enable,            // Port on
   input  wire logic [3:0]        mode_field,             // Mode select
   input  wire logic              scl_dir,                // 1 = input
   input  wire logic              sda_dir,                // 1 = input
   input  wire logic              slew_control,           // Slew bit
   input  wire logic [BYTE_W-1:0] slave_address_register, // Own address
   input  wire logic              address_write,          // Address written
   input  wire logic [BYTE_W-1:0] address_mask_register,  // 1 = compare
   input  wire logic              clock_release_set,      // Release pulse
   input  wire logic [BYTE_W-1:0] tx_byte,                // Byte to send
   input  wire logic              tx_load,                // Load tx_byte
   input  wire logic              flag_clear,             // Clear flags
   output logic [BYTE_W-1:0]      rx_byte,                // Received byte
   output logic                   rx_valid,               // Byte waiting
   input  wire logic              rx_ready,               // Byte taken
   output logic                   start_seen,             // Last was start
   output logic                   stop_seen,              // Last was stop
   output logic                   address_update_needed,  // Rewrite addr
   output logic                   port_interrupt_flag,    // Event flag
   output logic                   clock_release,          // Clock let go
   output logic                   read_not_write,         // Master reads
   output logic                   data_not_address,       // Last was data
   output logic                   receive_overflow        // Byte dropped
);

   ////////////////////////////////////////////////////////////////////////
   // Mode decoding
   function automatic logic slave_on(input logic [3:0] m);
      return (m == MODE_SLV7) || (m == MODE_SLV10) ||
             (m == MODE_SLV7_SP) || (m == MODE_SLV10_SP);
   endfunction

   function automatic logic ten_bit(input logic [3:0] m);
      return (m == MODE_SLV10) || (m == MODE_SLV10_SP);
   endfunction

   function automatic logic sp_events(input logic [3:0] m);
      return (m == MODE_SLV7_SP) || (m == MODE_SLV10_SP) ||
             (m == MODE_FW_IDLE);                                // RULE18
   endfunction

   // Clear mask bit is a don't care
   function automatic logic masked_eq(input logic [BYTE_W-1:0] a,
                                      input logic [BYTE_W-1:0] b,
                                      input logic [BYTE_W-1:0] m);
      return ((a ^ b) & m) == '0;                                // RULE23
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and bus condition detection
   logic [2:0] scl_sync;
   logic [2:0] sda_sync;
   logic       scl_s;
   logic       sda_s;
   logic       scl_rise;
   logic       scl_fall;
   logic       bus_start;
   logic       bus_stop;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_sync <= 3'h7;
         sda_sync <= 3'h7;
      end else begin
         scl_sync <= {scl_sync[1:0], scl_in};
         sda_sync <= {sda_sync[1:0], sda_in};
      end
   end

   always_comb begin
      scl_s     = scl_sync[1];
      sda_s     = sda_sync[1];
      scl_rise  = scl_s && !scl_sync[2];
      scl_fall  = !scl_s && scl_sync[2];
      bus_start = scl_s && scl_sync[2] && !sda_s && sda_sync[2];
      bus_stop  = scl_s && scl_sync[2] && sda_s && !sda_sync[2];
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive buffer
   sps_stream_if #(.WIDTH(BYTE_W)) push_s ();
   sps_stream_if #(.WIDTH(BYTE_W)) pop_s ();

   sps_rx_fifo #(.WIDTH(BYTE_W), .DEPTH(RX_DEPTH)) u_rx_fifo (
      .clk   (clk),
      .rst_b (rst_b),
      .in_s  (push_s.snk),
      .out_s (pop_s.src)
   );

   assign rx_byte      = pop_s.data;
   assign rx_valid     = pop_s.valid;
   assign pop_s.ready  = rx_ready;

   ////////////////////////////////////////////////////////////////////////
   // Protocol engine
   sps_state_t        state,    next_state;
   logic [3:0]        bits,     next_bits;
   logic [BYTE_W-1:0] shreg,    next_shreg;                      // RULE8
   logic [BYTE_W-1:0] tx_hold,  next_tx_hold;
   logic [BYTE_W-1:0] push_d,   next_push_d;
   logic              push_v,   next_push_v;
   logic [1:0]        ten_st,   next_ten_st;
   logic              loaded,   next_loaded;
   logic              sda_drv,  next_sda_drv;
   logic              scl_drv,  next_scl_drv;
   logic              next_start, next_stop, next_ua, next_flag;
   logic              next_ckp, next_rnw, next_dna, next_ovf;
   logic              next_scl_oe_b, next_sda_oe_b, next_slew;
   logic [BYTE_W-1:0] rbyte;
   logic              hit;
   logic              set_flag;

   assign push_s.data  = push_d;
   assign push_s.valid = push_v;

   always_comb begin
      next_state   = state;
      next_bits    = bits;
      next_shreg   = shreg;
      next_tx_hold = tx_load ? tx_byte : tx_hold;
      next_push_d  = push_d;
      next_push_v  = push_v && !push_s.ready;
      next_ten_st  = ten_st;
      next_loaded  = loaded;
      next_sda_drv = sda_drv;
      next_start   = start_seen;
      next_stop    = stop_seen;
      next_ua      = address_update_needed && !address_write;    // RULE11
      next_ckp     = clock_release || clock_release_set;         // RULE10
      next_rnw     = read_not_write;
      next_dna     = data_not_address;
      next_ovf     = receive_overflow && !flag_clear;
      set_flag     = 1'b0;
      rbyte        = {shreg[BYTE_W-2:0], sda_s};
      hit          = 1'b0;

      if (bus_start) begin
         next_start = 1'b1;                                      // RULE14
         next_stop  = 1'b0;
         set_flag   = sp_events(mode_field);                     // RULE2
      end
      if (bus_stop) begin
         next_start  = 1'b0;                                     // RULE14
         next_stop   = 1'b1;
         set_flag    = sp_events(mode_field);                    // RULE19
         next_ten_st = TEN_NONE;
      end

      if (bus_start || bus_stop) begin
         next_state   = bus_start && slave_on(mode_field) ? ST_ADDR
                                                          : ST_IDLE;
         next_bits    = '0;
         next_sda_drv = 1'b0;
         next_dna     = 1'b0;
      end else begin
         case (state)
            ST_ADDR: begin
               if (scl_rise) begin                               // RULE6
                  next_shreg = rbyte;
                  next_bits  = 4'(bits + 1'b1);
                  if (bits == LAST_BIT) begin
                     if (!ten_bit(mode_field)) begin              // RULE1
                        hit      = masked_eq(rbyte, slave_address_register,
                                   {address_mask_register[7:1], 1'b0});
                        next_rnw = rbyte[0];
                     end else if (rbyte[7:3] == TEN_PREFIX) begin
                        hit = masked_eq(rbyte, slave_address_register,
                              {5'h00, address_mask_register[2:1], 1'b0});
                        next_rnw = rbyte[0];
                        if (!rbyte[0]) begin
                           next_ten_st = hit ? TEN_HIGH_OK : TEN_NONE;
                           next_ua     = hit;                     // RULE9
                        end else begin
                           hit = hit && (ten_st == TEN_FULL_OK);
                        end
                     end else if (ten_st == TEN_HIGH_OK) begin
                        hit = masked_eq(rbyte, slave_address_register,
                                        address_mask_register);
                        next_ten_st = hit ? TEN_FULL_OK : TEN_NONE;
                        next_ua     = hit;                        // RULE12
                        next_rnw    = 1'b0;
                     end
                     if (hit) begin
                        set_flag = 1'b1;                          // RULE17
                        next_state = ST_ACK;                      // RULE21
                     end else begin
                        next_state = ST_IDLE;
                     end
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin                               // RULE6
                  if (!sda_drv) begin
                     next_sda_drv = 1'b1;                         // RULE5
                  end else begin
                     next_sda_drv = 1'b0;
                     next_bits    = '0;
                     next_loaded  = 1'b0;
                     if (!data_not_address && ten_st == TEN_HIGH_OK) begin
                        next_state = ST_ADDR;
                     end else begin
                        next_dna   = 1'b1;
                        next_ckp   = read_not_write ? 1'b0 : next_ckp; // RULE10
                        next_state = read_not_write ? ST_TX : ST_RX;
                     end
                  end
               end
            end
            ST_RX: begin
               if (scl_rise) begin
                  next_shreg = rbyte;
                  next_bits  = 4'(bits + 1'b1);
                  if (bits == LAST_BIT) begin
                     set_flag = 1'b1;                             // RULE17
                     if (push_s.ready && !push_v) begin
                        next_push_d = rbyte;
                        next_push_v = 1'b1;
                        next_state  = ST_ACK;
                     end else begin
                        next_ovf   = 1'b1;
                        next_state = ST_IDLE;
                     end
                  end
               end
            end
            ST_TX: begin
               if (!loaded) begin
                  // Load in low phase only
                  if (clock_release && !scl_s) begin
                     next_shreg   = tx_hold;
                     next_sda_drv = !tx_hold[BYTE_W-1];          // RULE5
                     next_loaded  = 1'b1;
                  end
               end else if (scl_rise) begin
                  next_bits = 4'(bits + 1'b1);
               end else if (scl_fall) begin                      // RULE6
                  if (bits == BYTE_BITS) begin
                     next_sda_drv = 1'b0;
                     next_state   = ST_MACK;
                  end else begin
                     next_shreg   = {shreg[BYTE_W-2:0], 1'b0};
                     next_sda_drv = !shreg[BYTE_W-2];
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  set_flag = 1'b1;                                // RULE17
                  if (!sda_s) begin
                     next_ckp    = 1'b0;                          // RULE10
                     next_bits   = '0;
                     next_loaded = 1'b0;
                     next_state  = ST_TX;
                  end else begin
                     next_state  = ST_IDLE;
                  end
               end
            end
            ST_IDLE: begin
               next_sda_drv = 1'b0;
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end

      // Hold clock low until released
      next_scl_drv = (scl_fall || scl_drv) &&
                     (!next_ckp || next_ua);                     // RULE9

      // Set wins over clear
      next_flag = (port_interrupt_flag && !flag_clear) || set_flag;

      if (!port_enable) begin
         next_state   = ST_IDLE;
         next_start   = 1'b0;                                     // RULE13
         next_stop    = 1'b0;
         next_ua      = 1'b0;
         next_ckp     = 1'b1;
         next_sda_drv = 1'b0;
         next_scl_drv = 1'b0;
         next_ten_st  = TEN_NONE;
         next_dna     = 1'b0;
         next_rnw     = 1'b0;
      end

      // Drive low only; clear direction bit pulls low
      next_scl_oe_b = !(port_enable &&
                        (next_scl_drv || !scl_dir));             // RULE4
      next_sda_oe_b = !(port_enable &&
                        (next_sda_drv || !sda_dir));             // RULE16
      next_slew     = port_enable && slew_control;               // RULE7
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state                 <= ST_IDLE;
         bits                  <= '0;
         shreg                 <= '0;
         tx_hold               <= '0;
         push_d                <= '0;
         push_v                <= 1'b0;
         ten_st                <= TEN_NONE;
         loaded                <= 1'b0;
         sda_drv               <= 1'b0;
         scl_drv               <= 1'b0;
         start_seen            <= 1'b0;                           // RULE13
         stop_seen             <= 1'b0;
         address_update_needed <= 1'b0;
         port_interrupt_flag   <= 1'b0;
         clock_release         <= 1'b1;
         read_not_write        <= 1'b0;
         data_not_address      <= 1'b0;
         receive_overflow      <= 1'b0;
         scl_out               <= 1'b0;
         sda_out               <= 1'b0;
         scl_oe_b              <= 1'b1;
         sda_oe_b              <= 1'b1;
         slew_limit            <= 1'b0;
      end else begin
         state                 <= next_state;
         bits                  <= next_bits;
         shreg                 <= next_shreg;
         tx_hold               <= next_tx_hold;
         push_d                <= next_push_d;
         push_v                <= next_push_v;
         ten_st                <= next_ten_st;
         loaded                <= next_loaded;
         sda_drv               <= next_sda_drv;
         scl_drv               <= next_scl_drv;
         start_seen            <= next_start;
         stop_seen             <= next_stop;
         address_update_needed <= next_ua;
         port_interrupt_flag   <= next_flag;
         clock_release         <= next_ckp;
         read_not_write        <= next_rnw;
         data_not_address      <= next_dna;
         receive_overflow      <= next_ovf;
         scl_out               <= 1'b0;
         sda_out               <= 1'b0;
         scl_oe_b              <= next_scl_oe_b;
         sda_oe_b              <= next_sda_oe_b;
         slew_limit            <= next_slew;
      end
   end

endmodule // sps_i2c_slave

// ### tb/sps_i2c_slave_props.sv
// Checker for the two-wire slave port top module.
// Assumes binding onto sps_i2c_slave; one clock domain.
`timescale 1ns/10ps
module sps_i2c_slave_props
   import sps_pkg::*;
(
   input wire logic clk, rst_b, scl_in, scl_out, scl_oe_b, sda_out,
   input wire logic sda_oe_b, slew_limit, port_enable, slew_control,
   input wire logic scl_dir, sda_dir, address_write, rx_valid, rx_ready,
   input wire logic start_seen, stop_seen, address_update_needed,
   input wire logic clock_release,
   input wire logic [BYTE_W-1:0] rx_byte
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence head_held_s; rx_valid && !rx_ready; endsequence
   sequence free_clk_s; clock_release && !address_update_needed && scl_dir;
   endsequence
   outs_low_a: assert property (!scl_out && !sda_out)
      else $error("pin data not low");
   slew_follow_a: assert property ($past(rst_b) |->
      slew_limit == $past(port_enable && slew_control)) else $error("slew");
   one_cond_a: assert property (!(start_seen && stop_seen))
      else $error("start and stop both set");
   off_clear_a: assert property (!port_enable |=>
      !start_seen && !stop_seen) else $error("status kept while off");
   dir_pull_a: assert property (port_enable && !scl_dir |->
      ##[1:2] !scl_oe_b) else $error("direction bit did not pull");
   addr_update_a: assert property (address_write |=>
      !address_update_needed) else $error("update flag kept");
   head_hold_a: assert property (head_held_s |=>
      rx_valid && $stable(rx_byte)) else $error("head lost");
   data_edge_a: assert property ($changed(sda_oe_b) && sda_dir &&
      $past(sda_dir) && port_enable |-> !$past(scl_in, 2))
      else $error("data changed while clock high");
   clk_free_a: assert property (free_clk_s [*3] |-> scl_oe_b)
      else $error("clock held without cause");
endmodule // sps_i2c_slave_props
bind sps_i2c_slave sps_i2c_slave_props u_props (.*);

// ### tb/sps_bus_master.sv
// Behavioural two-wire bus master, 200 ns bit period.
// Assumes pulled-up wires.
`timescale 1ns/10ps
module sps_bus_master (
   input  wire logic scl,      // Resolved clock wire
   input  wire logic sda,      // Resolved data wire
   output logic      scl_low,  // 1 = pull clock low
   output logic      sda_low   // 1 = pull data low
);
   initial {scl_low, sda_low} = 2'h0;
   task wait_high();
      repeat (400) if (!scl) #25;
   endtask
   task put_bit(input logic b, output logic r);
      sda_low = !b;
      #50 scl_low = 0;
      wait_high();
      r = sda;
      #100 scl_low = 1;
      #50;
   endtask
   task start();
      sda_low = 0;
      #100 scl_low = 0;
      wait_high();
      #100 sda_low = 1;
      #100 scl_low = 1;
      #50;
   endtask
   task stop();
      sda_low = 1;
      #50 scl_low = 0;
      wait_high();
      #100 sda_low = 0;
      #100;
   endtask
   task send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) put_bit(d[i], r);
      put_bit(1'h1, r);
      ack = !r;
   endtask
   task fetch(output logic [7:0] d, input logic nak);
      logic r;
      for (int i = 7; i >= 0; i--) put_bit(1'h1, d[i]);
      put_bit(nak, r);
   endtask
endmodule // sps_bus_master

// ### tb/tb_sps_i2c_slave.sv
// Self-checking bench for the two-wire slave port.
// Uses the master model and bound checker.
`timescale 1ns/10ps
module tb_sps_i2c_slave
   import sps_pkg::*;
;
   logic clk, rst_b, port_enable, scl_dir, sda_dir, slew_control, ack;
   logic address_write, clock_release_set, tx_load, flag_clear, rx_ready;
   logic [3:0] mode_field;
   logic [7:0] slave_address_register, address_mask_register, tx_byte, d;
   logic [7:0] rx_byte;
   logic scl_out, scl_oe_b, sda_out, sda_oe_b, slew_limit, rx_valid;
   logic start_seen, stop_seen, address_update_needed, port_interrupt_flag;
   logic clock_release, read_not_write, data_not_address, receive_overflow;
   logic m_scl_low, m_sda_low, scl_in, sda_in;
   logic [15:0] lfsr = 16'h20F2;
   logic [3:0] modes [5] = '{MODE_SLV7, MODE_SLV10, MODE_SLV7_SP,
                             MODE_SLV10_SP, MODE_FW_IDLE};
   int miscompares, compares, q[$];
   assign scl_in = !(m_scl_low || !scl_oe_b);
   assign sda_in = !(m_sda_low || !sda_oe_b);
   sps_i2c_slave u_sps_i2c_slave (.*);
   sps_bus_master u_mst (.scl(scl_in), .sda(sda_in), .scl_low(m_scl_low),
                         .sda_low(m_sda_low));
   initial begin
      clk = 1'h0;
      forever #12.5 clk = !clk;
   end
   function automatic logic [15:0] step(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task tick();
      @(posedge clk);
      #2;
   endtask
   task automatic pulse(ref logic s);
      tick();
      s = 1;
      tick();
      s = 0;
   endtask
   task chk(input string n, input logic [7:0] e, g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   task complete_run();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {port_enable, address_write, clock_release_set, tx_load} = 4'h0;
      {flag_clear, rx_ready, scl_dir, sda_dir, rst_b} = 5'h06;
      {slew_control, tx_byte, mode_field} = {lfsr[0], 8'h00, MODE_SLV7};
      slave_address_register = 8'hA4;
      address_mask_register = 8'hFB;
      repeat (20) @(posedge clk);
      #2 rst_b = 1;
      port_enable = 1;
      repeat (4) tick();
      foreach (modes[i]) begin
         mode_field = modes[i];
         pulse(flag_clear);
         u_mst.start();
         repeat (4) tick();
         chk("start_seen", 8'h01, {7'h00, start_seen});
         chk("start flag", 8'(i > 1), port_interrupt_flag);
         pulse(flag_clear);
         u_mst.stop();
         repeat (4) tick();
         chk("stop_seen", 8'h01, {7'h00, stop_seen});
         chk("stop flag", 8'(i > 1), port_interrupt_flag);
      end
      $display("event modes done");
      {mode_field, rx_ready} = {MODE_SLV7_SP, 1'h0};
      u_mst.start();
      u_mst.send(8'hA6, ack);
      chk("miss ack", 8'h00, ack);
      u_mst.start();
      u_mst.send(8'hA0, ack);
      chk("mask ack", 8'h01, ack);
      for (int i = 0; i < 34; i++) begin
         lfsr = step(lfsr);
         if (i < 33) q.push_back(lfsr[7:0]);
         u_mst.send(lfsr[7:0], ack);
         chk("fill ack", 8'(i < 33), ack);
      end
      u_mst.stop();
      chk("overflow", 8'h01, receive_overflow);
      while (q.size() > 0) begin
         repeat (4) tick();
         chk("rx_byte", 8'(q.pop_front()), rx_byte);
         pulse(rx_ready);
      end
      repeat (4) tick();
      chk("drained", 8'h00, rx_valid);
      $display("fill and drain done");
      u_mst.start();
      u_mst.send(8'hA5, ack);
      chk("read ack", 8'h01, ack);
      fork
         u_mst.fetch(d, 1'h1);
         begin
            repeat (30) tick();
            chk("held", 8'h00, scl_in);
            lfsr = step(lfsr);
            tx_byte = lfsr[7:0];
            pulse(tx_load);
            pulse(clock_release_set);
         end
      join
      chk("tx byte", lfsr[7:0], d);
      u_mst.stop();
      $display("read done");
      scl_dir = 0;
      repeat (4) tick();
      chk("dir pull", 8'h00, scl_in);
      scl_dir = 1;
      pulse(address_write);
      u_mst.start();
      repeat (4) tick();
      port_enable = 0;
      repeat (2) tick();
      chk("off start", 8'h00, start_seen);
      $display("disable done");
      complete_run();
   end
   initial begin
      #400000;
      miscompares++;
      complete_run();
   end
endmodule // tb_sps_i2c_slave
